// ---- logic/tes_timer_status.sv ----
// Timestamp counter with compare, overflow, event status and interrupt request logic
`timescale 1ns/100ps
`include "tes_cfg.svh"
module tes_timer_status #(
  parameter int ADDR_W = 8                      // Register address width
) (
  input  wire logic              clk,           // Module clock, 200 MHz
  input  wire logic              reset_n,       // Asynchronous reset, active low
  input  wire logic              tick,          // Counter advance enable from prescaler
  input  wire logic              id_match_clr,  // Identifier compare match clear pulse
  input  wire logic [ADDR_W-1:0] addr,          // Register byte address
  input  wire tes_pkg::tes_word_t wr_data,      // Write data
  input  wire logic              wr_en,         // Write strobe
  input  wire logic              rd_en,         // Read strobe
  output tes_pkg::tes_word_t     rd_data,       // Read data, valid one cycle after rd_en
  output logic                   irq            // Level interrupt request
);

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  if (ADDR_W < 6) begin : g_addr_chk
    $error("ADDR_W too small for the register map");
  end

  // ****************************************************************
  // Decode helper
  // ****************************************************************
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
    hit = (a == ADDR_W'(off));
  endfunction : hit

  // ****************************************************************
  // State
  // ****************************************************************
  tes_pkg::tes_word_t count;
  tes_pkg::tes_word_t compare0;
  tes_pkg::tes_word_t compare1;
  tes_pkg::tes_word_t start_offset;
  tes_pkg::tes_word_t irq_enable;
  logic               clr_on_cmp0;
  logic               compare1_match_flag;
  logic               compare0_match_flag;
  logic               timer_overflow_flag;
  logic               compare1_irq_flag;
  logic               compare0_irq_flag;
  logic               overflow_irq_flag;
  tes_pkg::tes_word_t timer_event_status;
  tes_pkg::tes_word_t interrupt_request_flags;
  tes_pkg::tes_load_e next_move;
  tes_pkg::tes_word_t next_rd_data;

  logic match0;
  logic match1;
  logic overflow;
  logic wr_cmp0;
  logic wr_cmp1;
  logic wr_offset;
  logic wr_ctrl;
  logic wr_irq_en;
  logic clr_cmp1;
  logic clr_cmp0;
  logic clr_ovf;

  assign wr_cmp0   = wr_en && hit(addr, `TES_OFF_CMP0);
  assign wr_cmp1   = wr_en && hit(addr, `TES_OFF_CMP1);
  assign wr_offset = wr_en && hit(addr, `TES_OFF_OFFSET);
  assign wr_ctrl   = wr_en && hit(addr, `TES_OFF_CTRL);
  assign wr_irq_en = wr_en && hit(addr, `TES_OFF_IRQ_EN);

  // Write-one-to-clear strokes on the request flags
  assign clr_cmp1 = wr_en && hit(addr, `TES_OFF_IRQ_CLR) && wr_data[`TES_IRQ_CMP1];
  assign clr_cmp0 = wr_en && hit(addr, `TES_OFF_IRQ_CLR) && wr_data[`TES_IRQ_CMP0];
  assign clr_ovf  = wr_en && hit(addr, `TES_OFF_IRQ_CLR) && wr_data[`TES_IRQ_OVF];

  // Rollover from all ones happens only on an advancing tick
  assign overflow = tick && (count == `TES_CNT_MAX);

  // ****************************************************************
  // Compare units
  // ****************************************************************
  tes_match u_match0 (
    .clk     (clk),
    .reset_n (reset_n),
    .count   (count),
    .compare (compare0),
    .match   (match0)
  );

  tes_match u_match1 (
    .clk     (clk),
    .reset_n (reset_n),
    .count   (count),
    .compare (compare1),
    .match   (match1)
  );

  // ****************************************************************
  // Software registers
  // ****************************************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      compare0 <= `TES_RST_WORD;
      compare1 <= `TES_RST_WORD;
    end else begin
      if (wr_cmp0) begin
        compare0 <= wr_data;
      end
      if (wr_cmp1) begin
        compare1 <= wr_data;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      start_offset <= `TES_RST_WORD;
      clr_on_cmp0  <= 1'b0;
      irq_enable   <= `TES_RST_WORD;
    end else begin
      if (wr_offset) begin
        start_offset <= wr_data;
      end
      if (wr_ctrl) begin
        clr_on_cmp0 <= wr_data[`TES_CTRL_CLR_CMP0];
      end
      if (wr_irq_en) begin
        irq_enable <= wr_data & `TES_IRQ_MASK;
      end
    end
  end

  // ****************************************************************
  // Timestamp counter
  // ****************************************************************
  // Every clearing event restarts from the offset, not from zero
  always_comb begin
    if (overflow || id_match_clr || (match0 && clr_on_cmp0)) begin
      next_move = tes_pkg::TES_RELOAD;
    end else if (tick) begin
      next_move = tes_pkg::TES_INC;
    end else begin
      next_move = tes_pkg::TES_HOLD;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count <= `TES_RST_WORD;
    end else begin
      case (next_move)
        tes_pkg::TES_RELOAD: begin
          count <= start_offset;
        end
        tes_pkg::TES_INC: begin
          count <= count + 16'h0001;
        end
        default: begin
          count <= count;
        end
      endcase
    end
  end

  // ****************************************************************
  // Event status flags
  // ****************************************************************
  // A new event in the clearing cycle wins, so no event is lost
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      compare1_match_flag <= 1'b0;
    end else if (match1) begin
      compare1_match_flag <= 1'b1;
    end else if (clr_cmp1) begin
      compare1_match_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      compare0_match_flag <= 1'b0;
    end else if (match0) begin
      compare0_match_flag <= 1'b1;
    end else if (clr_cmp0) begin
      compare0_match_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      timer_overflow_flag <= 1'b0;
    end else if (overflow) begin
      timer_overflow_flag <= 1'b1;
    end else if (clr_ovf) begin
      timer_overflow_flag <= 1'b0;
    end
  end

  // ****************************************************************
  // Interrupt request flags
  // ****************************************************************
  // Request flags always set; only the output is gated by the enables
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      compare1_irq_flag <= 1'b0;
      compare0_irq_flag <= 1'b0;
      overflow_irq_flag <= 1'b0;
    end else begin
      compare1_irq_flag <= match1 || (compare1_irq_flag && !clr_cmp1);
      compare0_irq_flag <= match0 || (compare0_irq_flag && !clr_cmp0);
      overflow_irq_flag <= overflow || (overflow_irq_flag && !clr_ovf);
    end
  end

  always_comb begin
    timer_event_status = `TES_RST_WORD;
    timer_event_status[`TES_BIT_CMP1] = compare1_match_flag;
    timer_event_status[`TES_BIT_CMP0] = compare0_match_flag;
    timer_event_status[`TES_BIT_OVF]  = timer_overflow_flag;
    interrupt_request_flags = `TES_RST_WORD;
    interrupt_request_flags[`TES_IRQ_CMP1] = compare1_irq_flag;
    interrupt_request_flags[`TES_IRQ_CMP0] = compare0_irq_flag;
    interrupt_request_flags[`TES_IRQ_OVF]  = overflow_irq_flag;
  end

  // One cycle late against the flags, which keeps the output a plain flop
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(interrupt_request_flags & irq_enable);
    end
  end

  // ****************************************************************
  // Read port
  // ****************************************************************
  // Status has no write decode of its own, so a write there is simply dropped
  always_comb begin
    next_rd_data = `TES_RST_WORD;
    if (rd_en) begin
      if (hit(addr, `TES_OFF_STATUS)) begin
        next_rd_data = timer_event_status & `TES_STATUS_MASK;
      end else if (hit(addr, `TES_OFF_COUNT)) begin
        next_rd_data = count;
      end else if (hit(addr, `TES_OFF_CMP0)) begin
        next_rd_data = compare0;
      end else if (hit(addr, `TES_OFF_CMP1)) begin
        next_rd_data = compare1;
      end else if (hit(addr, `TES_OFF_OFFSET)) begin
        next_rd_data = start_offset;
      end else if (hit(addr, `TES_OFF_CTRL)) begin
        next_rd_data[`TES_CTRL_CLR_CMP0] = clr_on_cmp0;
      end else if (hit(addr, `TES_OFF_IRQ_STAT)) begin
        next_rd_data = interrupt_request_flags;
      end else if (hit(addr, `TES_OFF_IRQ_EN)) begin
        next_rd_data = irq_enable;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_data <= `TES_RST_WORD;
    end else begin
      rd_data <= next_rd_data;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_clr1;
    clr_cmp1 && !match1;
  endsequence

  sequence s_clr0;
    clr_cmp0 && !match0;
  endsequence

  sequence s_status_read;
    rd_en && hit(addr, `TES_OFF_STATUS);
  endsequence

  property p_status_ro;
    wr_en && hit(addr, `TES_OFF_STATUS) && !match0 && !match1 && !overflow
      |=> $stable(timer_event_status);
  endproperty
  a_status_ro: assert property (p_status_ro)
    else $error("status changed on a write");

  property p_reserved_zero;
    s_status_read |=> (rd_data[15:3] == 13'h0000) && (rd_data[2:0] == $past(
      timer_event_status[2:0]));
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("status read returned wrong bits");

  property p_set_cmp1;
    match1 |=> compare1_match_flag && compare1_irq_flag;
  endproperty
  a_set_cmp1: assert property (p_set_cmp1)
    else $error("compare 1 flag not set");

  property p_zero_cmp1;
    (compare1 == `TES_RST_WORD) && !compare1_match_flag |=> !compare1_match_flag;
  endproperty
  a_zero_cmp1: assert property (p_zero_cmp1)
    else $error("zero compare 1 matched");

  property p_clr_cmp1;
    s_clr1 |=> !compare1_match_flag && !compare1_irq_flag;
  endproperty
  a_clr_cmp1: assert property (p_clr_cmp1)
    else $error("compare 1 flag not cleared");

  property p_set_cmp0;
    match0 |=> compare0_match_flag;
  endproperty
  a_set_cmp0: assert property (p_set_cmp0)
    else $error("compare 0 flag not set");

  property p_zero_cmp0;
    (compare0 == `TES_RST_WORD) && !compare0_match_flag |=> !compare0_match_flag;
  endproperty
  a_zero_cmp0: assert property (p_zero_cmp0)
    else $error("zero compare 0 matched");

  property p_clr_cmp0;
    s_clr0 |=> !compare0_match_flag;
  endproperty
  a_clr_cmp0: assert property (p_clr_cmp0)
    else $error("compare 0 flag not cleared");

  property p_overflow;
    tick && (count == `TES_CNT_MAX) |=> timer_overflow_flag && overflow_irq_flag;
  endproperty
  a_overflow: assert property (p_overflow)
    else $error("overflow flag not set");

  property p_clr_ovf;
    clr_ovf && !overflow |=> !timer_overflow_flag && !overflow_irq_flag;
  endproperty
  a_clr_ovf: assert property (p_clr_ovf)
    else $error("overflow flag not cleared");

  property p_reload;
    overflow && !wr_offset |=> (count == $past(start_offset));
  endproperty
  a_reload: assert property (p_reload)
    else $error("counter did not restart from offset");

  property p_irq_out;
    (|(interrupt_request_flags & irq_enable)) |=> irq;
  endproperty
  a_irq_out: assert property (p_irq_out)
    else $error("enabled request did not raise irq");

  property p_irq_masked;
    !(|(interrupt_request_flags & irq_enable)) |=> !irq;
  endproperty
  a_irq_masked: assert property (p_irq_masked)
    else $error("irq high with nothing enabled");

endmodule : tes_timer_status

// ---- logic/tes_cfg.svh ----
// Register map, field positions and reset values of the timer event status block
`ifndef TES_CFG_SVH
`define TES_CFG_SVH

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define TES_OFF_STATUS   8'h00
`define TES_OFF_COUNT    8'h04
`define TES_OFF_CMP0     8'h08
`define TES_OFF_CMP1     8'h0C
`define TES_OFF_OFFSET   8'h10
`define TES_OFF_CTRL     8'h14
`define TES_OFF_IRQ_STAT 8'h18
`define TES_OFF_IRQ_CLR  8'h1C
`define TES_OFF_IRQ_EN   8'h20

// ****************************************************************
// Field positions
// ****************************************************************
`define TES_BIT_CMP1      2
`define TES_BIT_CMP0      1
`define TES_BIT_OVF       0
`define TES_IRQ_CMP1      15
`define TES_IRQ_CMP0      14
`define TES_IRQ_OVF       13
`define TES_CTRL_CLR_CMP0 0

// ****************************************************************
// Reset values and constants
// ****************************************************************
`define TES_RST_WORD     16'h0000
`define TES_CNT_MAX      16'hFFFF
`define TES_STATUS_MASK  16'h0007
`define TES_IRQ_MASK     16'hE000

`endif

// ---- logic/tes_pkg.sv ----
// Shared types of the timer event status block
package tes_pkg;

  typedef logic [15:0] tes_word_t;

  // How the timestamp counter moves on a given cycle
  typedef enum logic [1:0] {
    TES_HOLD   = 2'b00,
    TES_INC    = 2'b01,
    TES_RELOAD = 2'b10
  } tes_load_e;

endpackage : tes_pkg

// ---- logic/tes_match.sv ----
// Compare unit: one-cycle pulse when the counter becomes equal to a nonzero compare value
`timescale 1ns/100ps
`include "tes_cfg.svh"
module tes_match (
  input  wire logic              clk,       // Module clock
  input  wire logic              reset_n,   // Asynchronous reset, active low
  input  wire tes_pkg::tes_word_t count,    // Current counter value
  input  wire tes_pkg::tes_word_t compare,  // Compare value
  output logic                   match      // Pulse on the cycle equality begins, for a nonzero compare value only
);

  logic equal;
  logic equal_prev;

  assign equal = (count == compare);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      equal_prev <= 1'b0;
    end else begin
      equal_prev <= equal;
    end
  end

  // A zero compare value is disabled so a pass through zero never matches
  assign match = equal && !equal_prev && (compare != `TES_RST_WORD);

endmodule : tes_match

// ---- testbench/tb.sv ----
// Self-checking testbench for the timer event status block
`timescale 1ns/100ps
`include "tes_cfg.svh"
module tb;

  // ****************************************************************
  // Clock, reset and design ports
  // ****************************************************************
  logic               clk;
  logic               reset_n;
  logic               tick;
  logic               id_match_clr;
  logic [7:0]         addr;
  tes_pkg::tes_word_t wr_data;
  logic               wr_en;
  logic               rd_en;
  tes_pkg::tes_word_t rd_data;
  logic               irq;
  int                 fail_count;
  int                 n_tests;

  always #2.5 clk = ~clk;

  tes_timer_status #(
    .ADDR_W       (8)
  ) DUT (
    .clk          (clk),
    .reset_n      (reset_n),
    .tick         (tick),
    .id_match_clr (id_match_clr),
    .addr         (addr),
    .wr_data      (wr_data),
    .wr_en        (wr_en),
    .rd_en        (rd_en),
    .rd_data      (rd_data),
    .irq          (irq)
  );

  // ****************************************************************
  // Bus and check tasks
  // ****************************************************************
  task automatic chk(input string name, input tes_pkg::tes_word_t seen,
                     input tes_pkg::tes_word_t exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input tes_pkg::tes_word_t d);
    @(posedge clk);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge clk);
    wr_en   <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rchk(input string name, input logic [7:0] a, input tes_pkg::tes_word_t exp);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    chk(name, rd_data, exp);
  endtask : rchk

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask : idle

  // Pulses are spaced by an idle cycle, one count each
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk);
      tick <= 1'b1;
      @(posedge clk);
      tick <= 1'b0;
    end
  endtask : ticks

  task automatic irq_chk(input tes_pkg::tes_word_t exp);
    idle(2);
    #1;
    chk("irq", {15'h0000, irq}, exp);
  endtask : irq_chk

  task automatic results;
    $display("Comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : results

  // ****************************************************************
  // Watchdog
  // ****************************************************************
  initial begin
    repeat (100000) @(posedge clk);
    fail_count++;
    results();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    clk          = 1'b0;
    reset_n      = 1'b0;
    tick         = 1'b0;
    id_match_clr = 1'b0;
    addr         = 8'h00;
    wr_data      = 16'h0000;
    wr_en        = 1'b0;
    rd_en        = 1'b0;
    fail_count   = 0;
    n_tests      = 0;
    idle(2);
    reset_n <= 1'b1;

    rchk("status", `TES_OFF_STATUS, 16'h0000);
    rchk("irq_stat", `TES_OFF_IRQ_STAT, 16'h0000);
    rchk("count", `TES_OFF_COUNT, 16'h0000);
    chk("irq", {15'h0000, irq}, 16'h0000);
    $display("reset test done");

    // Writes to the status word and reserved bits must leave nothing behind
    wr(`TES_OFF_STATUS, 16'h0007);
    wr(`TES_OFF_IRQ_STAT, 16'hFFFF);
    rchk("status", `TES_OFF_STATUS, 16'h0000);
    rchk("irq_stat", `TES_OFF_IRQ_STAT, 16'h0000);
    rchk("unmapped", 8'h40, 16'h0000);
    $display("read only test done");

    // Compare 1 match, masking and clearing
    wr(`TES_OFF_CMP1, 16'h0003);
    wr(`TES_OFF_IRQ_EN, 16'h8000);
    ticks(3);
    idle(2);
    rchk("status", `TES_OFF_STATUS, 16'h0004);
    // A write of zero to the status word must not clear a set flag
    wr(`TES_OFF_STATUS, 16'h0000);
    rchk("status", `TES_OFF_STATUS, 16'h0004);
    rchk("irq_stat", `TES_OFF_IRQ_STAT, 16'h8000);
    irq_chk(16'h0001);
    wr(`TES_OFF_IRQ_EN, 16'h0000);
    irq_chk(16'h0000);
    rchk("irq_stat", `TES_OFF_IRQ_STAT, 16'h8000);
    wr(`TES_OFF_IRQ_EN, 16'h8000);
    wr(`TES_OFF_IRQ_CLR, 16'h8000);
    rchk("status", `TES_OFF_STATUS, 16'h0000);
    rchk("irq_stat", `TES_OFF_IRQ_STAT, 16'h0000);
    irq_chk(16'h0000);
    $display("compare 1 test done");

    // Compare 0 match with counter reload from the offset
    wr(`TES_OFF_OFFSET, 16'hFFF0);
    wr(`TES_OFF_CTRL, 16'h0001);
    wr(`TES_OFF_CMP0, 16'h0006);
    wr(`TES_OFF_IRQ_EN, 16'h4000);
    ticks(3);
    idle(3);
    rchk("count", `TES_OFF_COUNT, 16'hFFF0);
    rchk("status", `TES_OFF_STATUS, 16'h0002);
    rchk("irq_stat", `TES_OFF_IRQ_STAT, 16'h4000);
    irq_chk(16'h0001);
    wr(`TES_OFF_IRQ_CLR, 16'h4000);
    rchk("status", `TES_OFF_STATUS, 16'h0000);
    irq_chk(16'h0000);
    $display("compare 0 test done");

    // Overflow through zero with both compare values at zero
    wr(`TES_OFF_CTRL, 16'h0000);
    wr(`TES_OFF_OFFSET, 16'h0000);
    wr(`TES_OFF_CMP0, 16'h0000);
    wr(`TES_OFF_CMP1, 16'h0000);
    wr(`TES_OFF_IRQ_EN, 16'h2000);
    ticks(15);
    idle(2);
    rchk("count", `TES_OFF_COUNT, 16'hFFFF);
    rchk("status", `TES_OFF_STATUS, 16'h0000);
    ticks(1);
    idle(2);
    rchk("count", `TES_OFF_COUNT, 16'h0000);
    ticks(2);
    idle(2);
    rchk("status", `TES_OFF_STATUS, 16'h0001);
    rchk("irq_stat", `TES_OFF_IRQ_STAT, 16'h2000);
    irq_chk(16'h0001);
    wr(`TES_OFF_IRQ_CLR, 16'h2000);
    rchk("status", `TES_OFF_STATUS, 16'h0000);
    irq_chk(16'h0000);
    $display("overflow test done");

    // Identifier match clear reloads the counter from the offset
    wr(`TES_OFF_OFFSET, 16'h0123);
    @(posedge clk);
    id_match_clr <= 1'b1;
    @(posedge clk);
    id_match_clr <= 1'b0;
    idle(2);
    rchk("count", `TES_OFF_COUNT, 16'h0123);
    ticks(1);
    idle(2);
    rchk("count", `TES_OFF_COUNT, 16'h0124);
    $display("offset reload test done");

    // Flags set, then a reset in mid-run must wipe them
    wr(`TES_OFF_CMP1, 16'h0125);
    ticks(1);
    idle(2);
    rchk("status", `TES_OFF_STATUS, 16'h0004);
    @(posedge clk);
    reset_n <= 1'b0;
    idle(2);
    reset_n <= 1'b1;
    rchk("status", `TES_OFF_STATUS, 16'h0000);
    $display("second reset test done");

    results();
  end

endmodule : tb
